// ==== common/rpb_map.svh ====
`ifndef RPB_MAP_SVH
`define RPB_MAP_SVH
// Register offsets (word index on the plain port)
`define RPB_ADDR_W        3
`define RPB_REG_CTRL      3'h0
`define RPB_REG_SLEEP     3'h1
`define RPB_REG_NCHK      3'h2
`define RPB_REG_LIM_MIN   3'h3
`define RPB_REG_LIM_MAX   3'h4
`define RPB_REG_STATUS    3'h5
// Field positions
`define RPB_CTRL_POLL_BIT 0
`define RPB_SLEEP_XSEL    5
`define RPB_LIM_W         6
`define RPB_SLEEP_W       5
// Reset values
`define RPB_RST_LIM_MIN   6'h0E
`define RPB_RST_LIM_MAX   6'h18
`define RPB_RST_SLEEP     5'h01
`define RPB_RST_NCHK      2'h1
// Timing
`define RPB_SLEEP_UNIT    1024
`define RPB_SLEEP_EXTEND_SELECT_MUL    8
`define RPB_DIV_BASE      16
`define RPB_DIV_CHECK     8
`define RPB_PLL_WAIT      64
`define RPB_SIG_WAIT      128
`endif

// ==== common/rpb_pkg.sv ====
package rpb_pkg;
  typedef enum logic [4:0] {
    RPB_IDLE    = 5'b0_0001,
    RPB_SLEEP   = 5'b0_0010,
    RPB_PLL     = 5'b0_0100,
    RPB_SIGPROC = 5'b0_1000,
    RPB_CHECK   = 5'b1_0000
  } rpb_state_type;

  typedef struct packed {
    logic       poll_enable;
    logic [4:0] sleep_setting;
    logic       sleep_extend_select;
    logic [1:0] checked_bits;
    logic [5:0] lim_min;
    logic [5:0] lim_max;
  } rpb_cfg_type;

  typedef struct packed {
    logic synth_enable;
    logic sigproc_enable;
    logic rx_active;
    logic receiving;
  } rpb_ctl_type;
endpackage : rpb_pkg

// ==== src/rpb_regs.sv ====
`timescale 1ns/10ps
`include "rpb_map.svh"
module rpb_regs
  import rpb_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire logic [`RPB_ADDR_W-1:0]  addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  input  wire logic [7:0]              status,
  output logic [7:0]                   rdata,
  output rpb_cfg_type                  cfg
);
  logic [7:0] ctrl_q;
  logic [7:0] sleep_q;
  logic [7:0] nchk_q;
  logic [7:0] lmin_q;
  logic [7:0] lmax_q;
  logic [7:0] rdata_d;

  always_comb
  begin
    unique case (addr)
      `RPB_REG_CTRL:    rdata_d = ctrl_q;
      `RPB_REG_SLEEP:   rdata_d = sleep_q;
      `RPB_REG_NCHK:    rdata_d = nchk_q;
      `RPB_REG_LIM_MIN: rdata_d = lmin_q;
      `RPB_REG_LIM_MAX: rdata_d = lmax_q;
      `RPB_REG_STATUS:  rdata_d = status;
      default:          rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_q  <= 8'h00;
      sleep_q <= {3'b000, `RPB_RST_SLEEP};
      nchk_q  <= {6'b00_0000, `RPB_RST_NCHK};
      lmin_q  <= {2'b00, `RPB_RST_LIM_MIN};
      lmax_q  <= {2'b00, `RPB_RST_LIM_MAX};
      rdata   <= 8'h00;
    end
    else
    begin
      if (wr && addr == `RPB_REG_CTRL)    ctrl_q  <= {7'h00, wdata[0]};
      if (wr && addr == `RPB_REG_SLEEP)   sleep_q <= {2'b00, wdata[5:0]};
      if (wr && addr == `RPB_REG_NCHK)    nchk_q  <= {6'h00, wdata[1:0]};
      if (wr && addr == `RPB_REG_LIM_MIN) lmin_q  <= {2'b00, wdata[5:0]};
      if (wr && addr == `RPB_REG_LIM_MAX) lmax_q  <= {2'b00, wdata[5:0]};
      rdata <= rd ? rdata_d : 8'h00;
    end
  end

  assign cfg.poll_enable         = ctrl_q[`RPB_CTRL_POLL_BIT];
  assign cfg.sleep_setting       = sleep_q[`RPB_SLEEP_W-1:0];
  assign cfg.sleep_extend_select = sleep_q[`RPB_SLEEP_XSEL];
  assign cfg.checked_bits        = nchk_q[1:0];
  assign cfg.lim_min             = lmin_q[`RPB_LIM_W-1:0];
  assign cfg.lim_max             = lmax_q[`RPB_LIM_W-1:0];
endmodule : rpb_regs

// ==== src/rpb_poll.sv ====
// What this block does
// - Loop sleep, start-up, bit-check while polling
// - Sleep lasts setting times 1024 base periods
// - Extension select gives factor one or eight
// - Synth lock first, then signal path, then check
// - Time edge intervals against programmable window
// - Bit count 0,3,6,9 means 0,6,12,18 checks
// - Interval inside window continues, outside returns sleep
// - Lower limit times period, upper minus one
// - Six-bit limits in fourth and fifth registers
// - Counter steps per check clock; ignore startup demod
// - Fail below lower at edge, or reaching upper
// - Noise check duration independent of bit count
// - All checks passed enters receiving mode
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "rpb_map.svh"
module rpb_poll
  import rpb_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic [`RPB_ADDR_W-1:0] addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic [7:0]                  rdata,
  input  wire logic                   demod_in,
  input  wire logic                   pll_lock,
  output logic                        synth_enable,
  output logic                        sigproc_enable,
  output logic                        rx_active,
  output logic                        receiving
);
  rpb_cfg_type   cfg;
  rpb_state_type state_q;
  rpb_state_type state_d;
  rpb_ctl_type   ctl_d;
  rpb_ctl_type   ctl_q;

  logic [7:0]  status;
  logic [4:0]  div_base_q;
  logic [3:0]  div_chk_q;
  logic        tick_base;
  logic        tick_chk;
  logic [17:0] sleep_cnt_q;
  logic [17:0] sleep_len;
  logic [7:0]  wait_q;
  logic [5:0]  cv_q;
  logic [4:0]  checks_q;
  logic [4:0]  checks_need;
  logic [2:0]  dm_sync_q;
  logic        dm_prev_q;
  logic        lk_sync_q1;
  logic        lk_sync_q2;
  logic        lk_sync_q3;
  logic        lock_q;
  logic        edge_seen;
  logic        too_short;
  logic        too_long;
  logic        last_check;

  rpb_regs u_regs (
    .clock  (clock),
    .rst    (rst),
    .addr   (addr),
    .wdata  (wdata),
    .wr     (wr),
    .rd     (rd),
    .status (status),
    .rdata  (rdata),
    .cfg    (cfg)
  );

  function automatic logic [4:0] check_count(input logic [1:0] nbits);
    check_count = 5'(nbits) * 5'd6;
  endfunction : check_count

  // Base and check clock enables from the system clock
  assign tick_base = (div_base_q == 5'(`RPB_DIV_BASE - 1));
  assign tick_chk  = (div_chk_q == 4'(`RPB_DIV_CHECK - 1));

  always_ff @(posedge clock)
  begin
    if (rst || tick_base)
      div_base_q <= 5'h0_0;
    else
      div_base_q <= div_base_q + 5'h0_1;
  end

  always_ff @(posedge clock)
  begin
    if (rst || tick_chk || state_q != RPB_CHECK)
      div_chk_q <= 4'h0;
    else
      div_chk_q <= div_chk_q + 4'h1;
  end

  // Pin synchronisers: change accepted when stages two and three agree
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dm_sync_q  <= 3'h0;
      dm_prev_q  <= 1'b0;
      lk_sync_q1 <= 1'b0;
      lk_sync_q2 <= 1'b0;
      lk_sync_q3 <= 1'b0;
      lock_q     <= 1'b0;
    end
    else
    begin
      dm_sync_q  <= {dm_sync_q[1:0], demod_in};
      if (dm_sync_q[1] == dm_sync_q[2])
        dm_prev_q <= dm_sync_q[2];
      lk_sync_q1 <= pll_lock;
      lk_sync_q2 <= lk_sync_q1;
      lk_sync_q3 <= lk_sync_q2;
      if (lk_sync_q2 == lk_sync_q3)
        lock_q <= lk_sync_q3;
    end
  end

  assign edge_seen = (dm_sync_q[1] == dm_sync_q[2])
                     && (dm_sync_q[2] != dm_prev_q);

  // Sleep length in base ticks
  assign sleep_len = cfg.sleep_extend_select
                   ? 18'(cfg.sleep_setting) * 18'(`RPB_SLEEP_UNIT)
                     * 18'(`RPB_SLEEP_EXTEND_SELECT_MUL)
                   : 18'(cfg.sleep_setting) * 18'(`RPB_SLEEP_UNIT);

  assign checks_need = check_count(cfg.checked_bits);
  assign too_short   = edge_seen && (cv_q < cfg.lim_min);
  assign too_long    = (cv_q >= cfg.lim_max);
  assign last_check  = (checks_q + 5'h0_1 >= checks_need);

  always_comb
  begin
    state_d = state_q;
    if (!cfg.poll_enable)
      state_d = RPB_IDLE;
    else
    begin
      unique case (state_q)
        RPB_IDLE:
          state_d = ctl_q.receiving ? RPB_IDLE : RPB_SLEEP;
        RPB_SLEEP:
          if (tick_base && sleep_cnt_q + 18'h0_0001 >= sleep_len)
            state_d = RPB_PLL;
        RPB_PLL:
          if (lock_q && wait_q >= 8'(`RPB_PLL_WAIT))
            state_d = RPB_SIGPROC;
        RPB_SIGPROC:
          if (tick_base && wait_q >= 8'(`RPB_SIG_WAIT))
            state_d = (checks_need == 5'h0_0) ? RPB_IDLE
                                               : RPB_CHECK;
        RPB_CHECK:
          if (too_short || (tick_chk && too_long))
            state_d = RPB_SLEEP;
          else if (edge_seen && last_check)
            state_d = RPB_IDLE;
        default:
          state_d = RPB_IDLE;
      endcase
    end
  end

  always_comb
  begin
    ctl_d.synth_enable   = (state_d == RPB_PLL) || (state_d == RPB_SIGPROC)
                           || (state_d == RPB_CHECK);
    ctl_d.sigproc_enable = (state_d == RPB_SIGPROC)
                           || (state_d == RPB_CHECK);
    ctl_d.rx_active      = ctl_d.synth_enable;
    ctl_d.receiving      = cfg.poll_enable &&
      (ctl_q.receiving || (state_q != RPB_IDLE && state_d == RPB_IDLE));
    if (ctl_d.receiving)
    begin
      ctl_d.synth_enable   = 1'b1;
      ctl_d.sigproc_enable = 1'b1;
      ctl_d.rx_active      = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q <= RPB_IDLE;
      ctl_q   <= '0;
    end
    else
    begin
      state_q <= state_d;
      ctl_q   <= ctl_d;
    end
  end

  // Sleep and start-up timers on the base enable
  always_ff @(posedge clock)
  begin
    if (rst || state_q != RPB_SLEEP)
      sleep_cnt_q <= 18'h0_0000;
    else if (tick_base)
      sleep_cnt_q <= sleep_cnt_q + 18'h0_0001;
  end

  always_ff @(posedge clock)
  begin
    if (rst || state_d != state_q)
      wait_q <= 8'h00;
    else if (tick_base && wait_q != 8'hFF)
      wait_q <= wait_q + 8'h01;
  end

  // Interval counter runs only in bit-check; demod ignored before
  always_ff @(posedge clock)
  begin
    if (rst || state_q != RPB_CHECK || edge_seen)
      cv_q <= 6'h00;
    else if (tick_chk && cv_q != 6'h3F)
      cv_q <= cv_q + 6'h01;
  end

  always_ff @(posedge clock)
  begin
    if (rst || state_q != RPB_CHECK)
      checks_q <= 5'h0_0;
    else if (edge_seen)
      checks_q <= checks_q + 5'h0_1;
  end

  assign status = {3'h0, state_q == RPB_CHECK, state_q == RPB_SIGPROC,
                   state_q == RPB_PLL, state_q == RPB_SLEEP,
                   ctl_q.receiving};

  assign synth_enable   = ctl_q.synth_enable;
  assign sigproc_enable = ctl_q.sigproc_enable;
  assign rx_active      = ctl_q.rx_active;
  assign receiving      = ctl_q.receiving;
endmodule : rpb_poll

// ==== sim/rpb_poll_checker.sv ====
`timescale 1ns/10ps
module rpb_poll_checker
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       pll_lock,
  input wire logic       synth_enable,
  input wire logic       sigproc_enable,
  input wire logic       rx_active,
  input wire logic       receiving
);
  logic [10:0] syn_q;
  logic [11:0] sig_q;
  logic [1:0]  lk_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Saturating on-time counters
  always_ff @(posedge clock)
  begin
    syn_q <= synth_enable ? syn_q + {10'h000, !syn_q[10]} : 11'h000;
    sig_q <= sigproc_enable ? sig_q + {11'h000, !sig_q[11]} : 12'h000;
    lk_q  <= pll_lock ? lk_q + {1'b0, !(&lk_q)} : 2'h0;
  end
  property p_rdata; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("stray read data");
  property p_rst;
    $past(rst) |-> !synth_enable && !rx_active && !receiving;
  endproperty
  a_rst: assert property (p_rst) else $error("active after reset");
  property p_order; sigproc_enable |-> synth_enable; endproperty
  a_order: assert property (p_order) else $error("path before synth");
  property p_start; $rose(rx_active) |-> synth_enable && !sigproc_enable;
  endproperty
  a_start: assert property (p_start) else $error("bad wake order");
  property p_pll; $rose(sigproc_enable) |-> syn_q >= 11'h3f0; endproperty
  a_pll: assert property (p_pll) else $error("synth wait short");
  property p_lock; $rose(sigproc_enable) |-> lk_q == 2'h3; endproperty
  a_lock: assert property (p_lock) else $error("path without lock");
  property p_sleep; !rx_active |-> !synth_enable && !sigproc_enable;
  endproperty
  a_sleep: assert property (p_sleep) else $error("powered in sleep");
  property p_recv; $rose(receiving) |-> sig_q >= 12'h7f0; endproperty
  a_recv: assert property (p_recv) else $error("early receive");
  c_recv: cover property ($rose(receiving));
  c_fail: cover property ($fell(rx_active) && !receiving);
  c_sig: cover property ($rose(sigproc_enable));
endmodule : rpb_poll_checker
bind rpb_poll rpb_poll_checker rpb_poll_checker_inst (.clock(clock),
  .rst(rst), .rd(rd), .rdata(rdata), .pll_lock(pll_lock),
  .synth_enable(synth_enable), .sigproc_enable(sigproc_enable),
  .rx_active(rx_active), .receiving(receiving));

// ==== sim/rpb_tx_model.sv ====
`timescale 1ns/10ps
module rpb_tx_model
(
  input  wire logic       clock,
  input  wire logic       synth_enable,
  input  wire logic       sigproc_enable,
  input  wire logic       go,
  input  wire logic [7:0] hp,
  output logic            pll_lock,
  output logic            demod_in = 1'b0,
  output logic [7:0]      edges = 8'h00
);
  logic [7:0] cnt_q = 8'h00;
  logic [5:0] lk_q = 6'h00;
  logic       tick;
  assign tick = go && cnt_q == hp - 8'h01;
  assign pll_lock = lk_q[5];
  always @(posedge clock)
  begin
    lk_q <= synth_enable ? lk_q + {5'h00, !lk_q[5]} : 6'h00;
    cnt_q <= (go && !tick) ? cnt_q + 8'h01 : 8'h00;
    edges <= go ? edges + {7'h00, tick} : 8'h00;
    // Demodulator output is noise until the path is up
    if (!sigproc_enable || tick)
      demod_in <= ~demod_in;
  end
endmodule : rpb_tx_model

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`include "rpb_map.svh"
module tb;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       go = 1'b0;
  logic [7:0] hp = 8'h10;
  logic [7:0] rdata, edges, s;
  logic       pll_lock, demod_in, synth_enable, sigproc_enable;
  logic       rx_active, receiving;
  logic [1:0] outs;
  int         failures = 0;
  int         n_compared = 0;
  int         n;
  assign outs = {receiving, rx_active};
  always #12.5 clock = ~clock;
  rpb_poll rpb_poll_inst (.clock(clock), .rst(rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .demod_in(demod_in),
    .pll_lock(pll_lock), .synth_enable(synth_enable),
    .sigproc_enable(sigproc_enable), .rx_active(rx_active),
    .receiving(receiving));
  rpb_tx_model rpb_tx_model_inst (.clock(clock), .synth_enable(synth_enable),
    .sigproc_enable(sigproc_enable), .go(go), .hp(hp), .pll_lock(pll_lock),
    .demod_in(demod_in), .edges(edges));
  function automatic logic [7:0] exp_rst(input int a);
    case (a)
      1, 2: return 8'h01;
      3: return 8'h0e;
      4: return 8'h18;
      default: return 8'h00;
    endcase
  endfunction : exp_rst
  task automatic results;
  begin
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask : results
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
  begin
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  end
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
  begin
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    d = rdata;
  end
  endtask : rd_reg
  task automatic wait_lvl(input int i, input logic v, input int lim);
  begin
    n = 0;
    while (outs[i] !== v && n < lim)
    begin
      @(negedge clock);
      n++;
    end
    if (n >= lim)
    begin
      failures++;
      results();
    end
  end
  endtask : wait_lvl
  // Polls status until the bit-check phase shows
  task automatic wait_chk;
  begin
    s = 8'h00;
    for (int k = 0; k < 3000 && s[4] !== 1'b1; k++)
      rd_reg(`RPB_REG_STATUS, s);
    if (s[4] !== 1'b1)
    begin
      failures++;
      results();
    end
  end
  endtask : wait_chk
  initial
  begin
    void'($urandom(32'hb3a2));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int a = 0; a < 8; a++)
    begin
      rd_reg(3'(a), s);
      chk(s, exp_rst(a));
    end
    wr_reg(`RPB_REG_LIM_MIN, 8'hff);
    rd_reg(`RPB_REG_LIM_MIN, s);
    chk(s, 8'h3f);
    wr_reg(`RPB_REG_LIM_MIN, 8'h0e);
    wr_reg(`RPB_REG_SLEEP, 8'h21);
    rd_reg(`RPB_REG_SLEEP, s);
    chk(s, 8'h21);
    wr_reg(`RPB_REG_SLEEP, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      hp <= 8'(8 * (16 + $urandom % 7));
      wr_reg(`RPB_REG_NCHK, 8'(c));
      wr_reg(`RPB_REG_CTRL, 8'h01);
      if (c != 0)
        wait_chk();
      go <= c != 0;
      wait_lvl(1, 1'b1, 25000);
      chk(edges, 8'(6 * c));
      wr_reg(`RPB_REG_CTRL, 8'h00);
      go <= 1'b0;
    end
    for (int k = 0; k < 3; k++)
    begin
      hp <= k == 0 ? 8'h50 : 8'hf0;
      wr_reg(`RPB_REG_NCHK, k == 2 ? 8'h03 : 8'h01);
      wr_reg(`RPB_REG_CTRL, 8'h01);
      wait_chk();
      go <= k != 2;
      wait_lvl(0, 1'b0, 400);
      chk(edges, 8'(k == 0));
      chk(8'(receiving), 8'h00);
      if (k != 0)
        chk(8'(n >= 176 && n <= 208), 8'h01);
      go <= 1'b0;
      wr_reg(`RPB_REG_CTRL, 8'h00);
    end
    // One-unit sleep: receiver wakes after 1024 base periods, then polling is stopped
    wr_reg(`RPB_REG_SLEEP, 8'h01);
    wr_reg(`RPB_REG_CTRL, 8'h01);
    wait_lvl(0, 1'b1, 20000);
    chk(8'(n >= 16360 && n <= 16420), 8'h01);
    wr_reg(`RPB_REG_CTRL, 8'h00);
    wait_lvl(0, 1'b0, 40);
    results();
  end
endmodule : tb
